/* File: hdl/psm_pkg.sv */
package psm_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 40000000;
    localparam int SEQ_DELAY_US = 5000;
    localparam int SEQ_DELAY_CYC = SEQ_DELAY_US * (CLK_HZ / 1000000);
    localparam int SLOW_BLINK_MHZ = 500;
    localparam int FAST_BLINK_MHZ = 5000;
    // Half period in cycles: clk / (2 * f)
    localparam int SLOW_HALF_CYC = (CLK_HZ / (2 * SLOW_BLINK_MHZ)) * 1000;
    localparam int FAST_HALF_CYC = (CLK_HZ / (2 * FAST_BLINK_MHZ)) * 1000;
    localparam int CNT_W = 26;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RST_LAMP = 1'b0;
    localparam logic RST_REBOOT_N = 1'b0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        PSM_OFF,
        PSM_UP_REGS,
        PSM_UP_WAIT,
        PSM_ON,
        PSM_DN_WAIT
    } psm_state_t;

    // Battery status inputs
    typedef struct packed {
        logic battery_present_n;
        logic charge_rate_flag;
        logic mains_relay_energized;
        logic input_power_present;
    } psm_batt_t;

    // Regulator enables
    typedef struct packed {
        logic logic_rail_on;
        logic core_on;
        logic memory_on;
    } psm_regs_t;

endpackage : psm_pkg

/* File: hdl/psm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // ==========================================================
    // Two-flop synchroniser
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : psm_sync
`default_nettype wire

/* File: hdl/psm_top.sv */
// Function
// [R1] Drive line-fail and supply-fail open-drain lines
// [R2] Input power loss starts power-down
// [R3] Line-fail first, supply-fail 5 ms later
// [R4] After supply-fail, shut logic and core regulators
// [R5] Releasing local power request starts power-down
// [R6] Standby keeps memory regulator running
// [R7] Off mode shuts memory regulator too
// [R8] Remote controller requests power when no switch
// [R9] Grounded standby select makes remote-down standby
// [R10] Battery enable high keeps lamp dark
// [R11] Charging below 90 percent: blink 0.5 Hz
// [R12] Discharging: blink 5 Hz
// [R13] Above 90 percent charged: lamp steady on
// [R14] Variant one: both qualifiers low, lamp off
// [R15] Variant two: power-present replaces relay qualifier
// [R16] Variant two: lamp follows oscillator, held high
// [R17] Reboot request while memory rail low
// [R18] Processor reboots when request seen
// [R19] Release reboot request with line-fail release
// [R20] Output line-frequency tick following mains
// [R21] Power-up reverses the power-down order
// [R22] Delays and blink rates counted in clocks
`timescale 1ns/1ps
`default_nettype none
module psm_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Power inputs from comparators and switches
    input wire logic INPUT_POWER_GOOD,
    input wire logic LOCAL_POWER_ON_REQUEST,
    input wire logic REMOTE_POWER_REQUEST,
    input wire logic SWITCH_FITTED,
    input wire logic KEEP_MEMORY_POWERED_SELECT,
    input wire logic MEMORY_SUPPLY_RAIL_LOW,
    input wire logic MAINS_PHASE,
    // Battery monitor inputs
    input wire psm_pkg::psm_batt_t BATT,
    input wire logic LAMP_VARIANT_TWO,
    // Open-drain bus lines
    input wire logic LINE_FAIL_WARNING_N_IN,
    output logic LINE_FAIL_WARNING_N_OUT,
    output logic LINE_FAIL_WARNING_N_OE,
    input wire logic SUPPLY_FAIL_N_IN,
    output logic SUPPLY_FAIL_N_OUT,
    output logic SUPPLY_FAIL_N_OE,
    // Regulators and status
    output psm_pkg::psm_regs_t REGS,
    output logic LINE_FAIL_DRIVE,
    output logic REBOOT_REQUEST_N,
    output logic STATUS_LAMP,
    output logic LINE_FREQUENCY_TICK
);
    // ==========================================================
    // Input synchronisation
    // ==========================================================
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic pgood;
    logic local_req;
    logic remote_req;
    logic sw_fit;
    logic keep_memory_powered_select_gnd;
    logic mem_low;
    logic mains;
    psm_pkg::psm_batt_t batt;
    logic variant2;

    assign raw_in = {INPUT_POWER_GOOD, LOCAL_POWER_ON_REQUEST, REMOTE_POWER_REQUEST,
                     SWITCH_FITTED, KEEP_MEMORY_POWERED_SELECT, MEMORY_SUPPLY_RAIL_LOW,
                     MAINS_PHASE, BATT};

    psm_sync #(.W(NSYNC)) u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .d(raw_in),
        .q(syn)
    );

    assign {pgood, local_req, remote_req, sw_fit, keep_memory_powered_select_gnd, mem_low, mains, batt} = syn;
    assign variant2 = LAMP_VARIANT_TWO;

    // ==========================================================
    // Sequencer
    // ==========================================================
    psm_pkg::psm_state_t state_reg;
    logic [psm_pkg::CNT_W-1:0] seq_cnt_reg;
    psm_pkg::psm_state_t prev_state_reg;
    logic want_on;
    logic standby;
    logic seq_done;

    // Power request: switch, else remote controller
    assign want_on = pgood && (sw_fit ? local_req : remote_req); // R2 R5 R8
    // Standby for any power-down in remote mode with select grounded
    assign standby = !sw_fit && !keep_memory_powered_select_gnd; // R9
    // Stale count from the previous state is ignored for one cycle
    assign seq_done = (prev_state_reg == state_reg)
                   && (seq_cnt_reg == psm_pkg::CNT_W'(psm_pkg::SEQ_DELAY_CYC - 1)); // R22

    // State machine
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= psm_pkg::PSM_OFF;
        end else begin
            unique case (state_reg)
                psm_pkg::PSM_OFF: begin
                    if (want_on) begin
                        state_reg <= psm_pkg::PSM_UP_REGS;
                    end
                end
                psm_pkg::PSM_UP_REGS: begin
                    state_reg <= want_on ? psm_pkg::PSM_UP_WAIT : psm_pkg::PSM_OFF; // R21
                end
                psm_pkg::PSM_UP_WAIT: begin
                    if (!want_on) begin
                        state_reg <= psm_pkg::PSM_DN_WAIT;
                    end else if (seq_done) begin
                        state_reg <= psm_pkg::PSM_ON; // R21
                    end
                end
                psm_pkg::PSM_ON: begin
                    if (!want_on) begin
                        state_reg <= psm_pkg::PSM_DN_WAIT; // R2 R5
                    end
                end
                psm_pkg::PSM_DN_WAIT: begin
                    if (seq_done) begin
                        state_reg <= psm_pkg::PSM_OFF; // R3
                    end
                end
                default: state_reg <= psm_pkg::PSM_OFF;
            endcase
        end
    end

    // Delay counter, cleared on every state change
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_cnt_reg <= '0;
            prev_state_reg <= psm_pkg::PSM_OFF;
        end else begin
            prev_state_reg <= state_reg;
            if (prev_state_reg != state_reg || seq_done) begin
                seq_cnt_reg <= '0;
            end else begin
                seq_cnt_reg <= seq_cnt_reg + 1'b1; // R22
            end
        end
    end

    // Line drivers and regulator enables
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            LINE_FAIL_WARNING_N_OE <= 1'b1;
            SUPPLY_FAIL_N_OE <= 1'b1;
            LINE_FAIL_DRIVE <= 1'b1;
            REGS <= '0;
        end else begin
            // Warning asserted except when fully on
            LINE_FAIL_WARNING_N_OE <= (state_reg != psm_pkg::PSM_ON); // R1 R3 R21
            LINE_FAIL_DRIVE <= (state_reg != psm_pkg::PSM_ON);
            // Supply-fail asserted in off and first up step
            SUPPLY_FAIL_N_OE <= (state_reg == psm_pkg::PSM_OFF)
                             || (state_reg == psm_pkg::PSM_UP_REGS); // R1 R3 R21
            // Regulators off only once fully down
            REGS.logic_rail_on <= (state_reg != psm_pkg::PSM_OFF); // R4 R21
            REGS.core_on <= (state_reg != psm_pkg::PSM_OFF); // R4
            REGS.memory_on <= (state_reg != psm_pkg::PSM_OFF)
                           || (standby && REGS.memory_on); // R6 R7
        end
    end

    // Open-drain lines only ever pull low
    assign LINE_FAIL_WARNING_N_OUT = 1'b0; // R1
    assign SUPPLY_FAIL_N_OUT = 1'b0; // R1

    // ==========================================================
    // Reboot request and line tick
    // ==========================================================
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REBOOT_REQUEST_N <= psm_pkg::RST_REBOOT_N;
            LINE_FREQUENCY_TICK <= 1'b0;
        end else begin
            if (mem_low) begin
                REBOOT_REQUEST_N <= 1'b0; // R17
            end else if (state_reg == psm_pkg::PSM_ON && LINE_FAIL_WARNING_N_OE) begin
                // Only on the edge that releases the warning line
                REBOOT_REQUEST_N <= 1'b1; // R19
            end
            LINE_FREQUENCY_TICK <= mains; // R20
        end
    end

    // ==========================================================
    // Battery lamp
    // ==========================================================
    logic [psm_pkg::CNT_W-1:0] slow_cnt_reg;
    logic [psm_pkg::CNT_W-1:0] fast_cnt_reg;
    logic slow_osc_reg;
    logic fast_osc_reg;
    logic qual;
    logic lamp_next;

    // Blink oscillators
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            slow_cnt_reg <= '0;
            fast_cnt_reg <= '0;
            slow_osc_reg <= 1'b0;
            fast_osc_reg <= 1'b0;
        end else begin
            if (slow_cnt_reg == psm_pkg::CNT_W'(psm_pkg::SLOW_HALF_CYC - 1)) begin
                slow_cnt_reg <= '0;
                slow_osc_reg <= !slow_osc_reg; // R11 R22
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 1'b1;
            end
            if (fast_cnt_reg == psm_pkg::CNT_W'(psm_pkg::FAST_HALF_CYC - 1)) begin
                fast_cnt_reg <= '0;
                fast_osc_reg <= !fast_osc_reg; // R12 R22
            end else begin
                fast_cnt_reg <= fast_cnt_reg + 1'b1;
            end
        end
    end

    // Second qualifier per variant
    assign qual = variant2 ? batt.input_power_present : batt.mains_relay_energized; // R15

    // Lamp mapping
    always_comb begin
        lamp_next = 1'b0;
        if (!batt.battery_present_n) begin // R10
            unique case ({batt.charge_rate_flag, qual})
                2'b01: lamp_next = slow_osc_reg; // R11
                2'b10: lamp_next = fast_osc_reg; // R12
                2'b11: lamp_next = 1'b1; // R13 R16
                2'b00: lamp_next = variant2; // R14 R16
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            STATUS_LAMP <= psm_pkg::RST_LAMP;
        end else begin
            STATUS_LAMP <= lamp_next;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_lamp_dark: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
        batt.battery_present_n |=> !STATUS_LAMP)
        else $error("lamp lit with battery enable high");
    chk_lamp_steady: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R13
        (!batt.battery_present_n && batt.charge_rate_flag && qual) |=> STATUS_LAMP)
        else $error("lamp not steady when charged");
    chk_fail_order: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
        $rose(SUPPLY_FAIL_N_OE) |-> LINE_FAIL_WARNING_N_OE && $past(LINE_FAIL_WARNING_N_OE))
        else $error("supply-fail before line-fail");
    chk_regs_after: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        $fell(REGS.core_on) |-> SUPPLY_FAIL_N_OE)
        else $error("regulators off before supply-fail");
    chk_down_start: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2 R5
        (state_reg == psm_pkg::PSM_ON && !want_on) |=> ##1 LINE_FAIL_WARNING_N_OE)
        else $error("power-down not started");
    chk_reboot_low: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R17
        mem_low |=> !REBOOT_REQUEST_N)
        else $error("reboot request not asserted");
    chk_reboot_rel: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R19
        $rose(REBOOT_REQUEST_N) |-> $fell(LINE_FAIL_WARNING_N_OE))
        else $error("reboot released apart from line-fail");
    chk_mem_off: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        ($fell(REGS.core_on) && !standby) |-> !REGS.memory_on)
        else $error("memory regulator left on in off mode");
    chk_tick: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R20
        LINE_FREQUENCY_TICK == $past(mains))
        else $error("tick does not follow mains");
endmodule : psm_top
`default_nettype wire

/* File: tb/psm_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_far_model (
    // Open-drain drivers from the block
    input wire logic lf_oe,
    input wire logic lf_out,
    input wire logic sf_oe,
    input wire logic sf_out,
    output logic lf_line,
    output logic sf_line,
    // Battery unit controls
    input wire logic unit_on,
    input wire logic dead,
    input wire logic chg,
    input wire logic relay,
    input wire logic pwr,
    output psm_pkg::psm_batt_t batt,
    // Processor view of the reboot request
    input wire logic reboot_n,
    output logic reboot_due
);
    // ==========================================================
    // Bus lines with pull-ups
    // ==========================================================
    // Low while pulled down, high from the pull-up otherwise
    assign lf_line = lf_oe ? lf_out : 1'b1;
    assign sf_line = sf_oe ? sf_out : 1'b1;

    // ==========================================================
    // Battery unit
    // ==========================================================
    // Enable held low only while on with a live battery
    assign batt = {~(unit_on & ~dead), chg, relay, pwr};

    // ==========================================================
    // Processor
    // ==========================================================
    // Reboot marked while request and warning both stand
    assign reboot_due = ~reboot_n & ~lf_line;
endmodule : psm_far_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Row: on, dead, chg, relay, pwr, var2, mains, expected lamp
    typedef struct packed {
        logic on, dead, chg, relay, pwr, var2, mains, lamp;
    } psm_row_t;
    localparam psm_row_t ROWS [8] = '{
        8'h02,
        8'h90,
        8'ha0,
        8'hf8,
        8'hb3,
        8'h88,
        8'haf,
        8'h95
    };
    logic clk = 1'b0, rst_n = 1'b0, pgood = 1'b0, local_req = 1'b0, remote_req = 1'b0;
    logic fitted = 1'b1, keep_sel = 1'b1, rail_low = 1'b0, mains = 1'b0, var2 = 1'b0;
    logic on = 1'b0, dead = 1'b0, chg = 1'b0, relay = 1'b0, pwr = 1'b0;
    logic lf_in, lf_out, lf_oe, sf_in, sf_out, sf_oe, lf_drive, reboot_n, lamp, tick;
    logic reboot_due;
    psm_pkg::psm_batt_t batt;
    psm_pkg::psm_regs_t regs;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    psm_top psm_top_i (.REF_CLK(clk), .RST_N(rst_n), .INPUT_POWER_GOOD(pgood),
        .LOCAL_POWER_ON_REQUEST(local_req), .REMOTE_POWER_REQUEST(remote_req),
        .SWITCH_FITTED(fitted), .KEEP_MEMORY_POWERED_SELECT(keep_sel),
        .MEMORY_SUPPLY_RAIL_LOW(rail_low), .MAINS_PHASE(mains), .BATT(batt),
        .LAMP_VARIANT_TWO(var2), .LINE_FAIL_WARNING_N_IN(lf_in),
        .LINE_FAIL_WARNING_N_OUT(lf_out), .LINE_FAIL_WARNING_N_OE(lf_oe),
        .SUPPLY_FAIL_N_IN(sf_in), .SUPPLY_FAIL_N_OUT(sf_out), .SUPPLY_FAIL_N_OE(sf_oe),
        .REGS(regs), .LINE_FAIL_DRIVE(lf_drive), .REBOOT_REQUEST_N(reboot_n),
        .STATUS_LAMP(lamp), .LINE_FREQUENCY_TICK(tick));

    psm_far_model psm_far_model_i (.lf_oe(lf_oe), .lf_out(lf_out), .sf_oe(sf_oe),
        .sf_out(sf_out), .lf_line(lf_in), .sf_line(sf_in), .unit_on(on), .dead(dead),
        .chg(chg), .relay(relay), .pwr(pwr), .batt(batt), .reboot_n(reboot_n),
        .reboot_due(reboot_due));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check_bit(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check_bit

    task automatic check_regs(input psm_pkg::psm_regs_t got, input psm_pkg::psm_regs_t exp,
        input string msg);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check_regs

    // Let n edges pass, then sample settled outputs
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, run needs about 90100 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        int i;
        wait_cyc(4);
        check_bit(lf_in, 1'b0, "line-fail not pulled in reset");
        check_bit(sf_in, 1'b0, "supply-fail not pulled in reset");
        check_regs(regs, 3'h0, "regulators on in reset");
        check_bit(reboot_n, 1'b0, "reboot request idle in reset");
        @(posedge clk) rst_n <= 1'b1;
        $display("reset test done");
        // Lamp and tick table
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            {on, dead, chg, relay, pwr, var2, mains} <= ROWS[i][7:1];
            wait_cyc(6);
            check_bit(lamp, ROWS[i].lamp, "status lamp");
            check_bit(tick, ROWS[i].mains, "line tick");
        end
        $display("lamp table done");
        // Rail low keeps reboot request asserted
        @(posedge clk) rail_low <= 1'b1;
        wait_cyc(6);
        check_bit(reboot_n, 1'b0, "reboot request not asserted");
        // Local power-up
        @(posedge clk) begin
            pgood <= 1'b1;
            local_req <= 1'b1;
            rail_low <= 1'b0;
        end
        for (i = 0; i < 20 && regs.logic_rail_on !== 1'b1; i++) wait_cyc(1);
        check_regs(regs, 3'h7, "regulators not enabled");
        check_bit(sf_in, 1'b0, "supply-fail released before regulators");
        wait_cyc(3);
        check_bit(sf_in, 1'b1, "supply-fail not released");
        check_bit(lf_in, 1'b0, "line-fail released with supply-fail");
        wait_cyc(90000);
        check_bit(lf_oe, 1'b1, "line-fail released early");
        check_bit(reboot_n, 1'b0, "reboot released before line-fail");
        check_bit(reboot_due, 1'b1, "processor not told to reboot");
        $display("power-up test done");
        // Local request dropped mid power-up with power still good
        @(posedge clk) local_req <= 1'b0;
        wait_cyc(6);
        check_bit(lf_drive, 1'b1, "line-fail drive not asserted");
        check_bit(lf_in, 1'b0, "line-fail not asserted first");
        check_bit(sf_in, 1'b1, "supply-fail asserted with line-fail");
        check_regs(regs, 3'h7, "regulators off before supply-fail");
        $display("power-down test done");
        // Reset in mid-run
        @(posedge clk) rst_n <= 1'b0;
        wait_cyc(2);
        check_bit(sf_oe, 1'b1, "supply-fail idle after reset");
        check_regs(regs, 3'h0, "regulators on after reset");
        $display("mid-run reset test done");
        // Remote mode, standby select grounded, one-cycle request
        @(posedge clk) begin
            rst_n <= 1'b1;
            fitted <= 1'b0;
            keep_sel <= 1'b0;
            remote_req <= 1'b0;
        end
        wait_cyc(6);
        check_regs(regs, 3'h0, "regulators on after reset release");
        @(posedge clk) remote_req <= 1'b1;
        @(posedge clk) remote_req <= 1'b0;
        wait_cyc(3);
        check_regs(regs, 3'h7, "remote request ignored");
        wait_cyc(1);
        check_regs(regs, 3'h1, "memory regulator not kept in standby");
        // Remote mode, off selection
        @(posedge clk) keep_sel <= 1'b1;
        wait_cyc(6);
        @(posedge clk) remote_req <= 1'b1;
        @(posedge clk) remote_req <= 1'b0;
        wait_cyc(3);
        check_regs(regs, 3'h7, "remote request ignored in off mode");
        wait_cyc(1);
        check_regs(regs, 3'h0, "memory regulator left on in off mode");
        $display("remote test done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
